// *** hdl/wkl_pkg.sv ***
package wkl_pkg;
  // number of wake-up lines handled by the block
  localparam int WKL_LINES = 16;
  // apb byte addresses, one aligned word per register
  localparam logic [7:0] OFS_WAKE_CTRL = 8'h00;
  localparam logic [7:0] OFS_WAKE_MASK = 8'h04;
  localparam logic [7:0] OFS_WAKE_POL = 8'h08;
  localparam logic [7:0] OFS_WAKE_PEND = 8'h0C;
  localparam logic [7:0] OFS_STOP_STAT = 8'h10;
  localparam logic [7:0] OFS_TOP_CTRL = 8'h14;
  localparam logic [7:0] OFS_EXT_CTRL = 8'h18;
  // wake_control_reg bit positions
  localparam int CTRL_STOP = 2;
  localparam int CTRL_SRC = 1;
  localparam int CTRL_WAKE = 0;
  // stop status bit positions
  localparam int STAT_EXIT = 0;
  localparam int STAT_HALT = 1;
  // top level control bit positions
  localparam int TOP_POL = 0;
  localparam int TOP_EN = 1;
  localparam int TOP_GIE = 2;
  localparam int TOP_NM = 3;
  localparam int TOP_PEND = 4;
  // shared channel bit positions
  localparam int EXT_MASK = 0;
  localparam int EXT_PEND = 1;
  // reset values and stop write sequence steps
  localparam logic [15:0] WAKE_RST = 16'h0000;
  localparam logic [1:0] STEP_IDLE = 2'h0;
  localparam logic [1:0] STEP_ONE = 2'h1;
  localparam logic [1:0] STEP_ZERO = 2'h2;
  localparam logic [1:0] STEP_BROKEN = 2'h3;
  // oscillator restart delay, a least time, so it rounds up
  localparam int CLK_PERIOD_NS = 8;
  localparam int OSC_RESTART_NS = 2000;
  localparam int OSC_RESTART_CYC = (OSC_RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 9;
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(OSC_RESTART_CYC - 1);
  // address type of the register bus
  typedef logic [7:0] wkl_addr_t;
  // control register fields
  typedef struct packed {
    logic stop;
    logic src_sel;
    logic wake_mode;
  } wkl_ctrl_t;
  localparam wkl_ctrl_t CTRL_RST = 3'h0;
  // power state of the core clock
  typedef enum {WKL_RUN, WKL_STOPPED, WKL_RESTART} wkl_state_t;
endpackage

// *** hdl/wkl_edge.sv ***
module wkl_edge #(
  parameter int N = 17
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [N-1:0] pin,
  output logic [N-1:0] lvl,
  output logic [N-1:0] rise,
  output logic [N-1:0] fall
);
  import wkl_pkg::*;
  // one synchroniser and edge detector per input line
  genvar i;
  for (i = 0; i < N; i++) begin : g_line
    logic meta_q; // first stage, read only by the second
    logic sync_q; // stable level
    logic prev_q; // level one cycle earlier
    // two-flop synchroniser then a delay for edge detection
    always_ff @(posedge clk) begin
      if (rst) begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
        prev_q <= 1'b0;
      end else begin
        meta_q <= pin[i];
        sync_q <= meta_q;
        prev_q <= sync_q;
      end
    end
    assign lvl[i] = sync_q;
    assign rise[i] = sync_q & ~prev_q;
    assign fall[i] = ~sync_q & prev_q;
  end
endmodule

// *** hdl/wkl_stop_wake.sv ***
// Behaviour
// - irq or dma ack aborts sequence, flags zero
// - good sequence with nmi low enters stop
// - wake line exit clears stop, sets exit
// - nmi exit keeps stop set, sets exit
// - nmi high on third write refuses stop
// - later nmi fall never enters stop
// - nmi rise in sequence aborts entry
// - wake event in sequence aborts, pending kept
// - exit flag sticky; filtered entry reads reset
// - unmasked wake line ends stop after restart
// - nmi rising edge is extra wake source
// - pending bits edge set, clearable while active
// - top pending on nmi edge, gated request
// - unmaskable bit sticky; request needs new edge
// - held nmi gives no stop, no service
// - nmi low before third write allows entry
// - shared channel triggers on rising edge only
// - clearing one pending re-raises shared edge
// - one zero one in consecutive writes
// - entry needs nmi low, mode, mask, clean
// - polarity bit picks falling or rising edge
// - source and mode bits gate requests
//
// Our own choices: the APB register port and the register addresses.
module wkl_stop_wake (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire wkl_pkg::wkl_addr_t PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [15:0] WAKE_LINES,
  input wire logic NMI,
  input wire logic IRQ_DMA_ACK,
  output logic STOP_MODE,
  output logic EXT_IRQ,
  output logic TOP_IRQ
);
  import wkl_pkg::*;

  wkl_ctrl_t ctrl_q, ctrl_d; // wake_control_reg
  logic [15:0] mask_q; // wake_mask_high and low
  logic [15:0] pol_q; // wake_polarity_high and low
  logic [15:0] pend_q, pend_d; // wake_pending_high and low
  logic exit_q, exit_d; // stop_exit_flag
  logic [4:0] top_q, top_d; // top level control and pending
  logic [1:0] ext_q, ext_d; // shared channel mask and pending
  logic [1:0] step_q, step_d; // position in the stop write sequence
  wkl_state_t state_q, state_d; // core clock state
  logic [CNT_W-1:0] cnt_q, cnt_d; // oscillator restart counter
  logic cause_nmi_q, cause_nmi_d; // stop was ended by nmi
  logic shared_prev_q; // shared line one cycle earlier
  logic [31:0] rdata_q; // read data captured in setup phase

  // bus decode
  wire apb_wr = PSEL & PENABLE & PWRITE;
  wire apb_setup_rd = PSEL & ~PENABLE & ~PWRITE;
  wire hit_ctrl = (PADDR == OFS_WAKE_CTRL);
  wire hit_mask = (PADDR == OFS_WAKE_MASK);
  wire hit_pol = (PADDR == OFS_WAKE_POL);
  wire hit_pend = (PADDR == OFS_WAKE_PEND);
  wire hit_stat = (PADDR == OFS_STOP_STAT);
  wire hit_top = (PADDR == OFS_TOP_CTRL);
  wire hit_ext = (PADDR == OFS_EXT_CTRL);
  wire mapped = hit_ctrl | hit_mask | hit_pol | hit_pend | hit_stat | hit_top | hit_ext;
  wire wr_ctrl = apb_wr & hit_ctrl;
  wire wr_pol = apb_wr & hit_pol;
  wire wr_pend = apb_wr & hit_pend;
  wire wr_stat = apb_wr & hit_stat;
  wire wr_top = apb_wr & hit_top;
  wire wr_ext = apb_wr & hit_ext;
  // any register write other than the stop bit breaks the sequence
  wire wr_other = apb_wr & ~hit_ctrl;
  wire wr_stop_bit = PWDATA[CTRL_STOP];

  // synchronised pins and their edges
  logic [16:0] pin_lvl, pin_rise, pin_fall;
  wkl_edge #(.N(17)) u_edge (
    .clk(CLK),
    .rst(SYS_RST),
    .pin({NMI, WAKE_LINES}),
    .lvl(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );
  wire nmi_lvl = pin_lvl[16];
  wire nmi_rise = pin_rise[16];
  wire nmi_fall = pin_fall[16];

  // per-line edge selection; 1 picks rising, 0 falling
  wire [15:0] wake_edge = (pol_q & pin_rise[15:0]) | (~pol_q & pin_fall[15:0]);
  // an edge that lands while polarity is rewritten is dropped
  wire [15:0] pend_set = wake_edge & ~{16{wr_pol}};
  wire [15:0] pend_live = pend_q & mask_q;
  wire any_live = |pend_live;
  // shared channel input and wake event gating
  wire shared_in = ctrl_q.src_sel & any_live;
  wire wake_ev = ctrl_q.wake_mode & any_live;
  // channel fires on the rising edge of the combined line only
  wire shared_rise = shared_in & ~shared_prev_q;
  // a write that clears a live pending drops the line for a cycle
  wire pend_cleared = wr_pend & (|(pend_live & ~PWDATA[15:0]));
  wire shared_seen = shared_in & ~pend_cleared;
  // top level edge follows its polarity bit
  wire top_edge = top_q[TOP_POL] ? nmi_rise : nmi_fall;

  // sequence events
  wire in_seq = (step_q != STEP_IDLE);
  // ack, nmi rising edge, fresh unmasked pending or foreign write
  wire abort = in_seq & (IRQ_DMA_ACK | nmi_rise | (|(pend_set & mask_q)) | wr_other);
  wire third_wr = wr_ctrl & (step_q == STEP_ZERO) & wr_stop_bit & ~abort;
  // entry conditions checked at the third write
  wire entry_ok = ctrl_q.wake_mode & ~any_live & (|mask_q);
  // nmi level sampled only at the third write
  wire third_refuse = third_wr & nmi_lvl;
  wire third_enter = third_wr & ~nmi_lvl & entry_ok;
  wire cnt_done = (cnt_q == '0);
  wire exit_now = (state_q == WKL_RESTART) & cnt_done;

  // sequence step tracking
  always_comb begin
    step_d = step_q;
    if (state_q != WKL_RUN) begin
      step_d = STEP_IDLE;
    end else if (abort) begin
      // a broken sequence waits for a zero write before a new try
      step_d = STEP_BROKEN;
    end else if (wr_ctrl) begin
      case (step_q)
        STEP_IDLE: step_d = wr_stop_bit ? STEP_ONE : STEP_IDLE;
        STEP_ONE: step_d = wr_stop_bit ? STEP_ONE : STEP_ZERO;
        STEP_ZERO: step_d = STEP_IDLE;
        STEP_BROKEN: step_d = wr_stop_bit ? STEP_BROKEN : STEP_IDLE;
        default: step_d = STEP_IDLE;
      endcase
    end
  end

  // control register and stop bit next value
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d.src_sel = PWDATA[CTRL_SRC];
      ctrl_d.wake_mode = PWDATA[CTRL_WAKE];
      ctrl_d.stop = wr_stop_bit;
    end
    if (wr_ctrl && step_q == STEP_BROKEN) begin
      // rest of a broken sequence must not set the bit
      ctrl_d.stop = 1'b0;
    end
    if (third_wr) begin
      // refused by nmi keeps the bit, bad conditions clear it
      ctrl_d.stop = third_refuse | third_enter;
    end
    if (abort) begin
      ctrl_d.stop = 1'b0;
    end
    if (exit_now && !cause_nmi_q) begin
      ctrl_d.stop = 1'b0; // wake line exit clears the bit
    end
  end

  // power state machine
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    cause_nmi_d = cause_nmi_q;
    case (state_q)
      WKL_RUN: begin
        // a held nmi after its fall is never looked at again
        if (third_enter) begin
          state_d = WKL_STOPPED;
        end
      end
      WKL_STOPPED: begin
        // unmasked wake line or nmi rise ends stop
        if (wake_ev || nmi_rise) begin
          state_d = WKL_RESTART;
          cnt_d = CNT_LOAD;
          cause_nmi_d = ~wake_ev;
        end
      end
      WKL_RESTART: begin
        // clock held until the oscillator has settled
        if (cnt_done) begin
          state_d = WKL_RUN;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: state_d = WKL_RUN;
    endcase
  end

  // exit flag: set on real exit, cleared by software or filtered entry
  always_comb begin
    exit_d = exit_q;
    if (wr_stat && !PWDATA[STAT_EXIT]) begin
      exit_d = 1'b0;
    end
    if (abort || third_refuse) begin
      exit_d = 1'b0; // filtered entry reads reset
    end
    if (exit_now) begin
      exit_d = 1'b1; // set wins over a clear
    end
  end

  // pending bits: software writes, edges set and win
  always_comb begin
    pend_d = wr_pend ? PWDATA[15:0] : pend_q;
    pend_d = pend_d | pend_set;
  end

  // top level bits; unmaskable only ever sets
  always_comb begin
    top_d = top_q;
    if (wr_top) begin
      top_d[TOP_GIE:TOP_POL] = PWDATA[TOP_GIE:TOP_POL];
      top_d[TOP_NM] = top_q[TOP_NM] | PWDATA[TOP_NM];
      top_d[TOP_PEND] = PWDATA[TOP_PEND];
    end
    if (top_edge) begin
      top_d[TOP_PEND] = 1'b1; // a held level gives no edge
    end
  end

  // shared channel; clearing one of several pendings re-arms it
  always_comb begin
    ext_d = ext_q;
    if (wr_ext) begin
      ext_d = PWDATA[EXT_PEND:EXT_MASK];
    end
    if (shared_rise) begin
      ext_d[EXT_PEND] = 1'b1;
    end
  end

  // read mux, reserved bits zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) rd_mux[2:0] = ctrl_q;
    if (hit_mask) rd_mux[15:0] = mask_q;
    if (hit_pol) rd_mux[15:0] = pol_q;
    if (hit_pend) rd_mux[15:0] = pend_q;
    if (hit_stat) rd_mux[STAT_HALT:STAT_EXIT] = {(state_q != WKL_RUN), exit_q};
    if (hit_top) rd_mux[4:0] = top_q;
    if (hit_ext) rd_mux[1:0] = ext_q;
  end

  // register update
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ctrl_q <= CTRL_RST;
      mask_q <= WAKE_RST;
      pol_q <= WAKE_RST;
      pend_q <= WAKE_RST;
      exit_q <= 1'b0;
      top_q <= 5'h00;
      ext_q <= 2'h0;
    end else begin
      ctrl_q <= ctrl_d;
      mask_q <= (apb_wr && hit_mask) ? PWDATA[15:0] : mask_q;
      pol_q <= wr_pol ? PWDATA[15:0] : pol_q;
      pend_q <= pend_d;
      exit_q <= exit_d;
      top_q <= top_d;
      ext_q <= ext_d;
    end
  end

  // sequencer, state and bus read capture
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      step_q <= STEP_IDLE;
      state_q <= WKL_RUN;
      cnt_q <= '0;
      cause_nmi_q <= 1'b0;
      shared_prev_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      step_q <= step_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
      cause_nmi_q <= cause_nmi_d;
      shared_prev_q <= shared_seen;
      rdata_q <= apb_setup_rd ? rd_mux : rdata_q;
    end
  end

  // zero wait state slave; unmapped access flags an error
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;
  assign PRDATA = rdata_q;
  assign STOP_MODE = (state_q != WKL_RUN);
  // channel request needs its mask and the global enable
  assign EXT_IRQ = ext_q[EXT_PEND] & ext_q[EXT_MASK] & top_q[TOP_GIE];
  // top request: unmaskable, or enabled and globally enabled
  assign TOP_IRQ = top_q[TOP_PEND] & (top_q[TOP_NM] | (top_q[TOP_EN] & top_q[TOP_GIE]));

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  sequence s_restart_begin;
    state_q == WKL_STOPPED ##1 state_q == WKL_RESTART;
  endsequence

  chk_ack_abort: assert property (
    in_seq && IRQ_DMA_ACK |=> !ctrl_q.stop && state_q == WKL_RUN && !exit_q)
    else $error("ack during sequence did not abort");

  chk_good_entry: assert property (
    third_enter |=> state_q == WKL_STOPPED && ctrl_q.stop)
    else $error("good sequence did not enter stop");

  chk_wake_exit: assert property (
    exit_now && !cause_nmi_q |=> !ctrl_q.stop && exit_q && state_q == WKL_RUN)
    else $error("wake exit flags wrong");

  chk_nmi_exit: assert property (
    exit_now && cause_nmi_q && !wr_ctrl |=> ctrl_q.stop && exit_q)
    else $error("nmi exit flags wrong");

  chk_nmi_refuse: assert property (
    third_refuse |=> ctrl_q.stop && !exit_q && state_q == WKL_RUN)
    else $error("nmi high did not refuse stop");

  chk_restart_delay: assert property (
    s_restart_begin |-> ##249 state_q == WKL_RESTART ##1 state_q == WKL_RUN)
    else $error("restart delay wrong");

  chk_entry_cause: assert property (
    state_q == WKL_RUN ##1 state_q == WKL_STOPPED |-> $past(third_wr) && $past(!nmi_lvl))
    else $error("stop entered without sequence");

  chk_pend_set: assert property (
    wake_edge[0] && !wr_pol |=> pend_q[0])
    else $error("edge did not set pending");

  chk_pend_clear: assert property (
    wr_pend && !PWDATA[0] && !wake_edge[0] |=> !pend_q[0])
    else $error("pending clear lost");

  chk_shared_edge: assert property (
    $rose(shared_in) && !wr_ext |=> ext_q[EXT_PEND])
    else $error("shared channel edge missed");

  chk_nm_sticky: assert property (
    top_q[TOP_NM] |=> top_q[TOP_NM])
    else $error("unmaskable bit cleared");

  sequence s_pend_rearm;
    pend_cleared ##1 shared_in;
  endsequence

  chk_shared_rearm: assert property (
    s_pend_rearm |=> ext_q[EXT_PEND])
    else $error("shared channel not raised again");

  chk_broken_clear: assert property (
    step_q == STEP_BROKEN |=> !ctrl_q.stop)
    else $error("broken sequence left stop set");
endmodule

// *** verification/wkl_pins.sv ***
// far side of the block: wake-up pins, nmi pin and the cpu acknowledge
module wkl_pins (
  input wire logic clk,
  output logic [15:0] wake_lines,
  output logic nmi,
  output logic irq_dma_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins start idle low, before the first edge
  initial begin
    wake_lines = 16'h0000;
    nmi = 1'b0;
    irq_dma_ack = 1'b0;
  end
  // clean levels only, since the lines are edge triggered a glitch would count
  task automatic drive(input logic [15:0] v);
    @(posedge clk);
    wake_lines <= v;
  endtask
  // nmi level, changed just after an edge
  task automatic set_nmi(input logic v);
    @(posedge clk);
    nmi <= v;
  endtask
  // one-cycle acknowledge, as the cpu does when it takes a request
  task automatic ack;
    @(posedge clk);
    irq_dma_ack <= 1'b1;
    @(posedge clk);
    irq_dma_ack <= 1'b0;
  endtask
endmodule

// *** verification/testbench.sv ***
// self-checking bench for the stop entry and wake-up block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import wkl_pkg::*;
  logic CLK;
  logic SYS_RST;
  logic PSEL;
  logic PENABLE;
  logic PWRITE;
  wkl_addr_t PADDR;
  logic [31:0] PWDATA;
  logic [31:0] PRDATA, rd;
  logic PREADY, PSLVERR, NMI, IRQ_DMA_ACK, STOP_MODE, EXT_IRQ, TOP_IRQ, err;
  logic [15:0] WAKE_LINES;
  int fail_count = 0;
  int n_tests = 0;
  // ordinary cases: address, write value, expected read back
  typedef struct {wkl_addr_t a; logic [31:0] w; logic [31:0] e;} wkl_row_t;
  wkl_row_t rows [6] = '{'{OFS_WAKE_MASK, 32'hFFFFFFFF, 32'h0000FFFF},
    '{OFS_WAKE_POL, 32'h000000FF, 32'h000000FF}, '{OFS_WAKE_CTRL, 32'h3, 32'h3},
    '{OFS_EXT_CTRL, 32'h1, 32'h1}, '{OFS_TOP_CTRL, 32'h4, 32'h4},
    '{8'h1C, 32'hFFFFFFFF, 32'h0}};
  // 125 MHz core clock
  always #4 CLK = ~CLK;
  wkl_stop_wake i_dut (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .WAKE_LINES(WAKE_LINES), .NMI(NMI), .IRQ_DMA_ACK(IRQ_DMA_ACK),
    .STOP_MODE(STOP_MODE), .EXT_IRQ(EXT_IRQ), .TOP_IRQ(TOP_IRQ));
  wkl_pins i_pins (.clk(CLK), .wake_lines(WAKE_LINES), .nmi(NMI), .irq_dma_ack(IRQ_DMA_ACK));
  // verdict and end of run, shared with the watchdog
  task automatic complete_run;
    if (fail_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // compare with four-state equality so an unknown never matches
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer; starts on an edge so two calls never collide in a time step
  task automatic apb(input logic w, input wkl_addr_t a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    // only the watchdog ends a transfer that never gets its ready
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wr(input wkl_addr_t a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string nm, input wkl_addr_t a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  // wait whole cycles, then step off the edge to sample settled outputs
  task automatic wt(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  // bounded wait for the oscillator restart to finish
  task automatic wait_run;
    for (int i = 0; i < 400 && STOP_MODE !== 1'b0; i++) wt(1);
  endtask
  // stop sequence 1,0,1 with wake mode kept; hit picks a disturbance before write three
  task automatic seq(input int hit);
    wr(OFS_WAKE_CTRL, 32'h1);
    wr(OFS_WAKE_CTRL, 32'h5);
    wr(OFS_WAKE_CTRL, 32'h1);
    if (hit == 1) i_pins.ack();
    if (hit == 2) i_pins.drive(16'h0001);
    if (hit == 3) i_pins.set_nmi(1'b0);
    wt(5);
    wr(OFS_WAKE_CTRL, 32'h5);
    wt(3);
  endtask
  // watchdog: the whole run takes a little over a thousand cycles
  initial begin
    repeat (20000) @(posedge CLK);
    fail_count++;
    complete_run();
  end
  initial begin
    CLK = 1'b0;
    SYS_RST = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0000_0000;
    repeat (10) @(posedge CLK);
    SYS_RST <= 1'b0;
    wt(4);
    for (int a = 0; a <= 24; a += 4) rdc("reset value", 8'(a), 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rdc("register row", rows[i].a, rows[i].e);
      chk("slave error", {31'h0, err}, {31'h0, rows[i].a > OFS_EXT_CTRL});
    end
    // software preparation before a stop request: line 0 rising, wake mode
    wr(OFS_WAKE_MASK, 32'h1);
    wr(OFS_WAKE_POL, 32'h3);
    wr(OFS_WAKE_CTRL, 32'h1);
    wr(OFS_EXT_CTRL, 32'h0);
    wr(OFS_WAKE_PEND, 32'h0);
    // good sequence, wake line exit after the restart delay
    seq(0);
    chk("stop entry", STOP_MODE, 1);
    i_pins.drive(16'h0001);
    wt(200);
    chk("restart hold", STOP_MODE, 1);
    wait_run();
    chk("run again", STOP_MODE, 0);
    rdc("ctrl after wake", OFS_WAKE_CTRL, 32'h1);
    rdc("exit flag", OFS_STOP_STAT, 32'h1);
    wr(OFS_WAKE_PEND, 32'h0);
    rdc("pending clear", OFS_WAKE_PEND, 32'h0);
    // nmi rising edge as exit source
    wr(OFS_STOP_STAT, 32'h0);
    i_pins.drive(16'h0000);
    seq(0);
    chk("stop entry", STOP_MODE, 1);
    i_pins.set_nmi(1'b1);
    wait_run();
    chk("nmi exit", STOP_MODE, 0);
    rdc("ctrl after nmi", OFS_WAKE_CTRL, 32'h5);
    rdc("exit after nmi", OFS_STOP_STAT, 32'h1);
    // nmi still high: refused entry, later fall does nothing
    wr(OFS_WAKE_CTRL, 32'h1);
    wr(OFS_STOP_STAT, 32'h0);
    seq(0);
    chk("held nmi", STOP_MODE, 0);
    rdc("ctrl refused", OFS_WAKE_CTRL, 32'h5);
    rdc("exit refused", OFS_STOP_STAT, 32'h0);
    i_pins.set_nmi(1'b0);
    wt(10);
    chk("nmi fall", STOP_MODE, 0);
    // nmi lowered just before write three still enters
    wr(OFS_WAKE_CTRL, 32'h1);
    i_pins.set_nmi(1'b1);
    wt(5);
    seq(3);
    chk("late nmi low", STOP_MODE, 1);
    i_pins.drive(16'h0001);
    wait_run();
    wr(OFS_WAKE_PEND, 32'h0);
    i_pins.drive(16'h0000);
    // acknowledge in mid-sequence; the exit flag left set must read reset
    seq(1);
    chk("ack abort", STOP_MODE, 0);
    rdc("ctrl ack", OFS_WAKE_CTRL, 32'h1);
    rdc("exit filtered", OFS_STOP_STAT, 32'h0);
    // wake edge in mid-sequence
    seq(2);
    chk("wake abort", STOP_MODE, 0);
    rdc("ctrl wake", OFS_WAKE_CTRL, 32'h1);
    rdc("pend wake", OFS_WAKE_PEND, 32'h1);
    wr(OFS_WAKE_PEND, 32'h0);
    i_pins.drive(16'h0000);
    // top level request, unmaskable and sticky
    wr(OFS_TOP_CTRL, 32'h9);
    i_pins.set_nmi(1'b1);
    wt(5);
    chk("top request", TOP_IRQ, 1);
    wr(OFS_TOP_CTRL, 32'h9);
    wt(5);
    chk("no retrigger", TOP_IRQ, 0);
    wr(OFS_TOP_CTRL, 32'h4);
    rdc("unmaskable kept", OFS_TOP_CTRL, 32'hC);
    // shared channel: two lines pending, clear one to re-raise
    wr(OFS_WAKE_MASK, 32'h3);
    wr(OFS_WAKE_CTRL, 32'h2);
    wr(OFS_EXT_CTRL, 32'h1);
    i_pins.drive(16'h0003);
    wt(5);
    chk("shared raise", EXT_IRQ, 1);
    wr(OFS_EXT_CTRL, 32'h1);
    wt(3);
    chk("shared level", EXT_IRQ, 0);
    wr(OFS_WAKE_PEND, 32'h2);
    wt(3);
    chk("shared again", EXT_IRQ, 1);
    // clear every pending in the safe order: mask, pendings, channel pending
    wr(OFS_EXT_CTRL, 32'h0);
    wr(OFS_WAKE_PEND, 32'h0);
    wr(OFS_EXT_CTRL, 32'h0);
    wt(3);
    rdc("channel cleared", OFS_EXT_CTRL, 32'h0);
    // reset in mid-run: only a hardware reset clears the unmaskable bit
    @(posedge CLK);
    SYS_RST <= 1'b1;
    repeat (2) @(posedge CLK);
    SYS_RST <= 1'b0;
    wt(4);
    rdc("top after reset", OFS_TOP_CTRL, 32'h0);
    chk("ext after reset", EXT_IRQ, 0);
    complete_run();
  end
endmodule
